/* verilog/dctc_pkg.sv */
// constants and types for the dual channel torque cutoff
package dctc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int FILTER_TIME_MS  = 1;
  localparam int FILTER_CYC      =
    (FILTER_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISC_TIME_MS    = 200;
  localparam int DISC_CYC        =
    DISC_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_CFG    = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_EVENT  = 4'hc;

  // control bits (write one to act)
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP  = 1;
  localparam int CTRL_RESET = 2;

  // indication select: 1 = fault, 0 = warning
  localparam int CFG_SEL_STOPPED = 0;
  localparam int CFG_SEL_RUNNING = 1;
  localparam logic [1:0] CFG_RESET_VAL = 2'h3;

  // event register: faults [3:0], warnings [5:4]
  localparam int EV_LOSS1    = 0;
  localparam int EV_LOSS2    = 1;
  localparam int EV_HWFAIL   = 2;
  localparam int EV_CUTFAULT = 3;
  localparam int EV_REJECT   = 4;
  localparam int EV_CUTWARN  = 5;
  localparam int EV_W        = 6;
  localparam logic [3:0] FAULT_MASK = 4'hf;

  // status bits
  localparam int ST_RUNNING = 0;
  localparam int ST_CUTOFF  = 1;
  localparam int ST_CH1     = 2;
  localparam int ST_CH2     = 3;
  localparam int ST_FAULT   = 4;
  localparam int ST_WARN    = 5;

  typedef enum logic {
    DCTC_STOPPED,
    DCTC_RUNNING
  } dctc_run_state_t;

endpackage : dctc_pkg

/* verilog/dctc_chan_if.sv */
// filtered level of one cutoff channel
`timescale 1ns/1ps
interface dctc_chan_if;
  logic level;
  modport src (output level);
  modport dst (input  level);
endinterface : dctc_chan_if

/* verilog/dctc_chan_filter.sv */
// synchroniser and pulse filter for one cutoff input
`timescale 1ns/1ps
module dctc_chan_filter
  import dctc_pkg::*;
#(
  parameter int FILT_CYC = FILTER_CYC
) (
  // clock and reset
  input  wire logic  clk_sys,
  input  wire logic  arst_n,
  // raw pin
  input  wire logic  pin_in,
  // filtered level
  dctc_chan_if.src   chan
);

  localparam int CW = $clog2(FILT_CYC + 1);

  logic          sync1_reg;
  logic          sync2_reg;
  logic          filt_reg;
  logic          filt_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // only a level held past the window is taken
  always_comb begin
    filt_next = filt_reg;
    cnt_next  = '0;
    if (sync2_reg != filt_reg) begin
      if (cnt_reg == CW'(FILT_CYC)) begin
        filt_next = sync2_reg;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      filt_reg  <= 1'b0;
      cnt_reg   <= '0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      filt_reg  <= filt_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign chan.level = filt_reg;

endmodule : dctc_chan_filter

/* verilog/dctc_torque_cutoff.sv */
// dual channel torque cutoff interlock with register slave
//
// Behaviour
// - de-energized cutoff inputs remove control voltage from power switches.
// - a setting selects which indication a channel loss reports.
// - indication depends on running or stopped when the channel dropped.
// - indication setting never affects the torque removal itself.
// - a running drive stops when one or both channels drop.
// - no start until both channels restored and all faults reset.
// - loss of a single channel raises a fault once held past the cross-compare window.
// - reset before restart needed only if the setting asks for a fault or a single channel loss tripped one.
// - no automatic restart; a fresh start command is needed.
// - start while cutoff open is rejected with a warning.
// - first channel open coasts motor and raises first channel fault.
// - second channel open coasts motor and raises second channel fault.
// - no braking on cutoff; restart blocked while contacts open.
// - each input ignores pulses up to 1 ms.
// - channels cross-compared; a mismatch trips a hardware failure fault.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module dctc_torque_cutoff
  import dctc_pkg::*;
#(
  parameter int FILT_CYC = FILTER_CYC,
  parameter int DISC_LIM = DISC_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // cutoff pins, high when energized
  input  wire logic        first_cutoff_input,
  input  wire logic        second_cutoff_input,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // power stage and indications
  output logic             gate_drive_en,
  output logic             motor_running,
  output logic             fault_active,
  output logic             warning_active
);

  localparam int DW = $clog2(DISC_LIM + 1);

  // channel filters
  dctc_chan_if ch1_if ();
  dctc_chan_if ch2_if ();

  dctc_chan_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_filt1 (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .pin_in  (first_cutoff_input),
    .chan    (ch1_if.src)
  );

  dctc_chan_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_filt2 (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .pin_in  (second_cutoff_input),
    .chan    (ch2_if.src)
  );

  logic ch1;
  logic ch2;
  logic cut;

  assign ch1 = ch1_if.level;
  assign ch2 = ch2_if.level;
  assign cut = !(ch1 && ch2);

  // bus slave state
  logic        wait_reg;
  logic        wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0]  cfg_reg;
  logic [1:0]  cfg_next;

  // interlock state
  dctc_run_state_t   state_reg;
  dctc_run_state_t   state_next;
  logic              cut_prev_reg;
  logic [DW-1:0]     disc_cnt_reg;
  logic [DW-1:0]     disc_cnt_next;
  logic [EV_W-1:0]   ev_reg;
  logic [EV_W-1:0]   ev_next;
  logic              gate_reg;
  logic              gate_next;
  logic              run_out_reg;
  logic              fault_out_reg;
  logic              fault_out_next;
  logic              warn_out_reg;
  logic              warn_out_next;

  // all reads passed in, so a continuous assign sees every change
  function automatic logic wr_hit(input logic       ok,
                                  input logic [3:0] adr,
                                  input logic [3:0] ofs);
    wr_hit = ok && (adr == ofs);
  endfunction : wr_hit

  logic            wr_ok;
  logic            ctrl_hit;
  logic            start_cmd;
  logic            stop_cmd;
  logic            reset_cmd;
  logic [EV_W-1:0] ev_w1c;

  assign wr_ok     = avs_write && !wait_reg && avs_byteenable[0];
  assign ctrl_hit  = wr_hit(wr_ok, avs_address, OFS_CTRL);
  assign start_cmd = ctrl_hit && avs_writedata[CTRL_START];
  assign stop_cmd  = ctrl_hit && avs_writedata[CTRL_STOP];
  assign reset_cmd = ctrl_hit && avs_writedata[CTRL_RESET];
  assign ev_w1c    = wr_hit(wr_ok, avs_address, OFS_EVENT)
                     ? avs_writedata[EV_W-1:0] : '0;

  // bus handshake: accept, then answer one cycle later
  always_comb begin
    wait_next  = 1'b1;
    rdata_next = rdata_reg;
    cfg_next   = cfg_reg;
    if (wait_reg && (avs_read || avs_write)) begin
      wait_next  = 1'b0;
      rdata_next = '0;
      case (avs_address)
        OFS_CFG: begin
          rdata_next[1:0] = cfg_reg;
        end
        OFS_STATUS: begin
          rdata_next[ST_RUNNING] = (state_reg == DCTC_RUNNING);
          rdata_next[ST_CUTOFF]  = cut;
          rdata_next[ST_CH1]     = ch1;
          rdata_next[ST_CH2]     = ch2;
          rdata_next[ST_FAULT]   = |(ev_reg[3:0] & FAULT_MASK);
          rdata_next[ST_WARN]    = |ev_reg[EV_W-1:4];
        end
        OFS_EVENT: begin
          rdata_next[EV_W-1:0] = ev_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
    if (wr_hit(wr_ok, avs_address, OFS_CFG)) begin
      cfg_next = avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg  <= 1'b1;
      rdata_reg <= '0;
      cfg_reg   <= CFG_RESET_VAL;
    end else begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
      cfg_reg   <= cfg_next;
    end
  end

  // interlock
  logic            fault_any;
  logic            cut_edge;
  logic            was_running;
  logic            sel_fault;
  logic            disc_trip;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  assign fault_any   = |(ev_reg[3:0] & FAULT_MASK);
  assign cut_edge    = cut && !cut_prev_reg;
  assign was_running = (state_reg == DCTC_RUNNING);
  assign sel_fault   = was_running ? cfg_reg[CFG_SEL_RUNNING]
                                   : cfg_reg[CFG_SEL_STOPPED];
  assign disc_trip   = (ch1 != ch2) && (disc_cnt_reg == DW'(DISC_LIM));

  always_comb begin
    ev_set     = '0;
    ev_clr     = ev_w1c;
    state_next = state_reg;
    // channel cross-compare, skew window tolerated
    disc_cnt_next = '0;
    if (ch1 != ch2) begin
      disc_cnt_next = disc_trip ? disc_cnt_reg : disc_cnt_reg + 1'b1;
    end
    if (disc_trip) begin
      ev_set[EV_HWFAIL] = 1'b1;
      ev_set[EV_LOSS1]  = !ch1;
      ev_set[EV_LOSS2]  = !ch2;
    end
    if (cut_edge) begin
      if (sel_fault) begin
        ev_set[EV_CUTFAULT] = 1'b1;
      end else begin
        ev_set[EV_CUTWARN] = 1'b1;
      end
    end
    if (reset_cmd) begin
      ev_clr[3:0] = FAULT_MASK;
    end
    // start/stop; cutoff wins over everything
    case (state_reg)
      DCTC_STOPPED: begin
        if (start_cmd && !cut && !fault_any) begin
          state_next = DCTC_RUNNING;
        end
      end
      DCTC_RUNNING: begin
        if (stop_cmd) begin
          state_next = DCTC_STOPPED;
        end
      end
      default: begin
        state_next = DCTC_STOPPED;
      end
    endcase
    if (cut || disc_trip) begin
      state_next = DCTC_STOPPED;
    end
    if (start_cmd && (cut || fault_any)) begin
      ev_set[EV_REJECT] = 1'b1;
    end
    // set wins over clear
    ev_next        = (ev_reg & ~ev_clr) | ev_set;
    gate_next      = (state_next == DCTC_RUNNING) && !cut;
    fault_out_next = |(ev_next[3:0] & FAULT_MASK);
    warn_out_next  = |ev_next[EV_W-1:4];
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= DCTC_STOPPED;
      cut_prev_reg  <= 1'b1;
      disc_cnt_reg  <= '0;
      ev_reg        <= '0;
      gate_reg      <= 1'b0;
      run_out_reg   <= 1'b0;
      fault_out_reg <= 1'b0;
      warn_out_reg  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cut_prev_reg  <= cut;
      disc_cnt_reg  <= disc_cnt_next;
      ev_reg        <= ev_next;
      gate_reg      <= gate_next;
      run_out_reg   <= (state_next == DCTC_RUNNING);
      fault_out_reg <= fault_out_next;
      warn_out_reg  <= warn_out_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign gate_drive_en   = gate_reg;
  assign motor_running   = run_out_reg;
  assign fault_active    = fault_out_reg;
  assign warning_active  = warn_out_reg;

endmodule : dctc_torque_cutoff

/* verif/dctc_switch_model.sv */
// switch contacts driving the two cutoff pins
`timescale 1ns/1ps
module dctc_switch_model (
  // clock
  input  wire logic clk_sys,
  // contacts, high when closed
  output logic      first_cutoff_input,
  output logic      second_cutoff_input
);
  initial begin
    first_cutoff_input  = 1'b0;
    second_cutoff_input = 1'b0;
  end

  // both contacts move on one edge
  task automatic set(input logic a, input logic b);
    @(posedge clk_sys);
    first_cutoff_input  <= a;
    second_cutoff_input <= b;
  endtask : set
endmodule : dctc_switch_model

/* verif/dctc_torque_cutoff_chk.sv */
// interlock checker bound to the cutoff top
`timescale 1ns/1ps
module dctc_torque_cutoff_chk
  import dctc_pkg::*;
#(
  parameter int FILT_CYC = FILTER_CYC,
  parameter int DISC_LIM = DISC_CYC
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        arst_n,
  // pins
  input wire logic        first_cutoff_input,
  input wire logic        second_cutoff_input,
  // bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  // outputs
  input wire logic        gate_drive_en,
  input wire logic        motor_running,
  input wire logic        fault_active,
  input wire logic        warning_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  int unsigned lo1_reg, lo1_next, lo2_reg, lo2_next;
  logic        start_w;
  assign start_w = avs_write && !avs_waitrequest
    && avs_address == OFS_CTRL && avs_writedata[CTRL_START];
  // cycles each pin has been low
  always_comb begin
    lo1_next = first_cutoff_input ? 0 : lo1_reg + 1;
    lo2_next = second_cutoff_input ? 0 : lo2_reg + 1;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lo1_reg <= 0;
      lo2_reg <= 0;
    end else begin
      lo1_reg <= lo1_next;
      lo2_reg <= lo2_next;
    end
  end
  cut_gate_a: assert property (
    (lo1_reg > FILT_CYC + 8 || lo2_reg > FILT_CYC + 8) |-> !gate_drive_en)
    else $error("gate on with a pin low");
  gate_run_a: assert property (gate_drive_en |-> motor_running)
    else $error("gate on while stopped");
  fresh_start_a: assert property (
    $rose(motor_running) |-> $past(start_w))
    else $error("run without start");
  clean_start_a: assert property (
    $rose(motor_running) |-> $past(fault_active) == 1'b0)
    else $error("run with fault");
  start_reject_a: assert property (
    start_w && fault_active |-> ##[1:3] (warning_active && !motor_running))
    else $error("start not rejected");
  single_loss_a: assert property (
    lo1_reg > DISC_LIM + FILT_CYC + 8 && second_cutoff_input |-> fault_active)
    else $error("no single channel fault");
  wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  bus_answer_a: assert property (
    $rose(avs_read || avs_write) |-> ##[1:2] !avs_waitrequest)
    else $error("bus answer late");
  cover property ($rose(motor_running));
  cover property (start_w && fault_active);
  cover property ($fell(gate_drive_en));
endmodule : dctc_torque_cutoff_chk

bind dctc_torque_cutoff dctc_torque_cutoff_chk #(
  .FILT_CYC (FILT_CYC),
  .DISC_LIM (DISC_LIM)
) u_chk (
  .clk_sys             (clk_sys),
  .arst_n              (arst_n),
  .first_cutoff_input  (first_cutoff_input),
  .second_cutoff_input (second_cutoff_input),
  .avs_address         (avs_address),
  .avs_read            (avs_read),
  .avs_write           (avs_write),
  .avs_writedata       (avs_writedata),
  .avs_waitrequest     (avs_waitrequest),
  .gate_drive_en       (gate_drive_en),
  .motor_running       (motor_running),
  .fault_active        (fault_active),
  .warning_active      (warning_active)
);

/* verif/test_dual_channel_torque_cutoff.sv */
// bench for the torque cutoff interlock
`timescale 1ns/1ps
module test_dual_channel_torque_cutoff;
  import dctc_pkg::*;
  localparam int FC = 4;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic [3:0]  adr     = 4'h0;
  logic        rd_q    = 1'b0;
  logic        wr_q    = 1'b0;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] rdat, q;
  logic        p1, p2, wt, gate, run, flt, wrn;
  int          errors     = 0;
  int          num_checks = 0;

  always #25 clk_sys = ~clk_sys;

  dctc_switch_model u_sw (.clk_sys(clk_sys), .first_cutoff_input(p1),
    .second_cutoff_input(p2));
  dctc_torque_cutoff #(.FILT_CYC(FC), .DISC_LIM(50)) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .first_cutoff_input(p1),
    .second_cutoff_input(p2), .avs_address(adr), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wdat), .avs_byteenable(4'hf),
    .avs_readdata(rdat), .avs_waitrequest(wt), .gate_drive_en(gate),
    .motor_running(run), .fault_active(flt), .warning_active(wrn));

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [31:0] e, s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr  <= a;
    wdat <= d;
    wr_q <= w;
    rd_q <= !w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wt !== 1'b0 && n < 20);
    q = rdat;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
    if (n >= 20) begin
      errors++;
      tally_and_finish;
    end
    @(posedge clk_sys);
  endtask : bus

  task automatic rchk(input string n, input logic [3:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask : rchk

  task automatic start;
    bus(1'b1, OFS_CTRL, 32'h1);
    cyc(2);
  endtask : start

  // clear events, reset faults, start
  task automatic restart;
    bus(1'b1, OFS_EVENT, 32'h3f);
    bus(1'b1, OFS_CTRL, 32'h4);
    start;
  endtask : restart

  task automatic pins(input logic a, b);
    u_sw.set(a, b);
    cyc(FC + 10);
  endtask : pins

  initial begin
    cyc(6);
    arst_n <= 1'b1;
    rchk("cfg", OFS_CFG, 32'h3);
    rchk("spare", 4'h2, 32'h0);
    chk("gate", 0, gate);
    pins(1, 1);
    chk("run", 0, run);
    restart;
    chk("run", 1, run);
    rchk("status", OFS_STATUS, 32'hd);
    u_sw.set(0, 1);
    cyc(FC - 1);
    pins(1, 1);
    chk("gate", 1, gate);
    $display("glitch test done");
    pins(0, 0);
    chk("gate", 0, gate);
    chk("run", 0, run);
    rchk("event", OFS_EVENT, 32'h8);
    chk("fault", 1, flt);
    start;
    chk("warn", 1, wrn);
    chk("run", 0, run);
    pins(1, 1);
    start;
    chk("run", 0, run);
    restart;
    chk("run", 1, run);
    $display("running cut test done");
    bus(1'b1, OFS_CTRL, 32'h2);
    bus(1'b1, OFS_CFG, 32'h1);
    bus(1'b1, OFS_EVENT, 32'h3f);
    pins(0, 0);
    rchk("event", OFS_EVENT, 32'h8);
    pins(1, 1);
    start;
    chk("run", 0, run);
    restart;
    pins(0, 0);
    rchk("event", OFS_EVENT, 32'h20);
    chk("gate", 0, gate);
    pins(1, 1);
    start;
    chk("run", 1, run);
    $display("indication test done");
    bus(1'b1, OFS_CFG, 32'h0);
    for (int c = 0; c < 2; c++) begin
      bus(1'b1, OFS_EVENT, 32'h3f);
      pins(c == 1, c == 0);
      chk("gate", 0, gate);
      cyc(60);
      bus(1'b1, OFS_CTRL, 32'h1);
      rchk("loss", OFS_EVENT, 32'h34 | (32'h1 << c));
      chk("fault", 1, flt);
      pins(1, 1);
      restart;
      chk("run", 1, run);
    end
    $display("single channel test done");
    arst_n <= 1'b0;
    cyc(2);
    chk("gate", 0, gate);
    chk("run", 0, run);
    arst_n <= 1'b1;
    rchk("cfg", OFS_CFG, 32'h3);
    cyc(FC + 10);
    chk("run", 0, run);
    $display("reset test done");
    tally_and_finish;
  end
endmodule : test_dual_channel_torque_cutoff
